//--- logic/capture_pkg.sv
// ==========================================================================
// shared constants and carriers of the interrupt flags / capture block
package capture_pkg;

   // ======================================================================
   // sizes
   localparam int TIMERS = 4;
   localparam int CHANNELS = 2;
   localparam int CNT_W_DEFAULT = 16;
   localparam int DATA_W = 32;
   localparam int ADDR_DEC_W = 8;
   localparam int CH_FIELD_W = 8;
   localparam int CH1_FIELD_BASE = 16;
   localparam int CAP_EVT_W = 2 * CHANNELS;

   // ======================================================================
   // register byte offsets within the block window
   localparam logic [ADDR_DEC_W-1:0] OFS_IRQ_EN = 8'h40;
   localparam logic [ADDR_DEC_W-1:0] OFS_IRQ_FLAGS = 8'h44;
   localparam logic [ADDR_DEC_W-1:0] OFS_CAP_CTRL = 8'h50;
   localparam logic [ADDR_DEC_W-1:0] OFS_CH0_RISE = 8'h58;
   localparam logic [ADDR_DEC_W-1:0] OFS_CH0_FALL = 8'h5C;
   localparam logic [ADDR_DEC_W-1:0] OFS_CH1_RISE = 8'h60;
   localparam logic [ADDR_DEC_W-1:0] OFS_CH1_FALL = 8'h64;
   localparam logic [ADDR_DEC_W-1:0] OFS_CAP_STATUS = 8'h70;
   localparam logic [ADDR_DEC_W-1:0] OFS_CAP_CLEAR = 8'h74;
   localparam logic [ADDR_DEC_W-1:0] OFS_CAP_IRQ_EN = 8'h78;

   // ======================================================================
   // reset values
   localparam logic [TIMERS-1:0] TIMER_RESET = 4'h0;
   localparam logic [CAP_EVT_W-1:0] CAP_EVT_RESET = 4'h0;
   localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;

   // ======================================================================
   // ahb-lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;
   localparam logic [1:0] ALIGN_WORD = 2'h0;

   // ======================================================================
   // one channel's byte of the capture control register, msb first
   typedef struct packed {
      logic fall_latch_dirty;
      logic rise_latch_dirty;
      logic reserved;
      logic capture_irq_ind;
      logic capture_enable;
      logic fall_irq_enable;
      logic rise_irq_enable;
      logic input_invert;
   } chan_ctrl_type;

   localparam chan_ctrl_type CHAN_CTRL_RESET = 8'h00;

   // edge pulses of one channel after capture gating
   typedef struct packed {
      logic rise;
      logic fall;
   } cap_evt_type;

endpackage : capture_pkg

//--- logic/capture_channel.sv
`timescale 1ns/1ps
// ==========================================================================
// one capture input: synchroniser, inverter, edge detect, latches
module capture_channel
   import capture_pkg::*;
#(
   parameter int CNT_W = CNT_W_DEFAULT
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // pin and control
   input wire logic cap_pin,
   input wire logic input_invert,
   input wire logic capture_enable,
   input wire logic [CNT_W-1:0] count_value,
   // results
   output cap_evt_type captured,
   output logic [CNT_W-1:0] rise_latch_value_q,
   output logic [CNT_W-1:0] fall_latch_value_q
);

   logic sync1_q;
   logic sync2_q;
   logic level;
   logic prev_q;
   logic rise_edge;
   logic fall_edge;

   // ======================================================================
   // synchroniser; first stage feeds only the second
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= cap_pin; // [R18]
         sync2_q <= sync1_q; // [R18]
      end
   end

   // toggling the inverter looks like an edge; software enables capture after
   assign level = sync2_q ^ input_invert; // [R8] [R11]

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level; // [R18]
      end
   end

   assign rise_edge = level & ~prev_q; // [R18]
   assign fall_edge = ~level & prev_q; // [R18]
   assign captured.rise = rise_edge & capture_enable; // [R5]
   assign captured.fall = fall_edge & capture_enable; // [R5]

   // ======================================================================
   // latches
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rise_latch_value_q <= '0;
         fall_latch_value_q <= '0;
      end else begin
         if (captured.rise) begin
            rise_latch_value_q <= count_value; // [R3] [R4]
         end
         if (captured.fall) begin
            fall_latch_value_q <= count_value; // [R3] [R4]
         end
      end
   end

endmodule : capture_channel

//--- logic/pwm_irq_flags_capture_ctrl.sv
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
// ==========================================================================
// Overview of operation
// R1 - four timer interrupt flags in bits 3..0 of the flags register, 1 is set
// R2 - writing zero to a flag bit clears only that flag
// R3 - channel 0 enable bit 3 latches counter on rising and falling edges
// R4 - channel 1 enable bit 19 latches its counter on matching edges
// R5 - disabled channel updates no latch and raises no capture interrupt
// R6 - channel 0 falling enable bit 2 raises interrupt on falling edge
// R7 - channel 0 rising enable bit 1 raises interrupt on rising edge
// R8 - bit 0 inverts channel 0 input before edge detection
// R9 - channel 1 falling enable bit 18 raises interrupt on falling edge
// R10 - channel 1 rising enable bit 17 raises interrupt on rising edge
// R11 - bit 16 inverts channel 1 input before edge detection
// R12 - bit 23 set when channel 1 falling latch is updated
// R13 - bit 22 set when channel 1 rising latch is updated
// R14 - bit 6 set when channel 0 rising latch is updated
// R15 - bits 4 and 20 show capture interrupt; while set, counter does not reload
// R16 - separate enable register, one bit per timer, 1 enables
// R17 - interrupt output high while any flag and its enable are set
// R18 - capture inputs synchronised, edges from successive samples after inversion
module pwm_irq_flags_capture_ctrl
   import capture_pkg::*;
#(
   parameter int CNT_W = CNT_W_DEFAULT
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // timer side
   input wire logic [TIMERS-1:0] timer_event,
   input wire logic [CHANNELS-1:0][CNT_W-1:0] counter_value,
   output logic [CHANNELS-1:0] counter_no_reload,
   // capture pins
   input wire logic [CHANNELS-1:0] cap_pin,
   // interrupt
   output logic irq
);

   // ======================================================================
   // elaboration checks
   if (CNT_W < 1 || CNT_W > DATA_W) begin : g_bad_width
      $error("counter width must lie between 1 and the bus width");
   end

   if ($bits(chan_ctrl_type) != CH_FIELD_W) begin : g_bad_field
      $error("channel control byte does not match its field width");
   end

   if (CH1_FIELD_BASE < CH_FIELD_W || CH1_FIELD_BASE + CH_FIELD_W > DATA_W) begin : g_bad_base
      $error("channel 1 field must sit above channel 0 inside the bus word");
   end

   if (CAP_EVT_W > DATA_W) begin : g_bad_evt
      $error("capture status must fit in one bus word");
   end

   if (TIMERS > DATA_W) begin : g_bad_timers
      $error("timer flags must fit in one bus word");
   end

   // ======================================================================
   // declarations
   logic addr_valid;
   logic wr_pend_q;
   logic [ADDR_DEC_W-1:0] wr_addr_q;
   logic [DATA_W-1:0] hrdata_q;
   logic [DATA_W-1:0] rd_val;
   logic wr_irq_en;
   logic wr_irq_flags;
   logic wr_cap_ctrl;
   logic wr_cap_clear;
   logic wr_cap_irq_en;

   logic [TIMERS-1:0] timer_irq_enables_q;
   logic [TIMERS-1:0] timer_irq_flags_q;
   logic [TIMERS-1:0] timer_irq_flags_d;

   chan_ctrl_type [CHANNELS-1:0] chan_q;
   chan_ctrl_type [CHANNELS-1:0] chan_d;
   cap_evt_type [CHANNELS-1:0] captured;
   logic [CHANNELS-1:0][CNT_W-1:0] rise_latch_value;
   logic [CHANNELS-1:0][CNT_W-1:0] fall_latch_value;
   logic [CHANNELS-1:0] rise_irq;
   logic [CHANNELS-1:0] fall_irq;

   logic [CAP_EVT_W-1:0] cap_status_q;
   logic [CAP_EVT_W-1:0] cap_status_d;
   logic [CAP_EVT_W-1:0] cap_irq_en_q;
   logic [CAP_EVT_W-1:0] cap_evt;
   logic [DATA_W-1:0] cap_ctrl_word;
   logic timer_irq_pend;
   logic cap_irq_pend;

   // ======================================================================
   // bus address phase
   // zero wait states: the slave never stalls, so hreadyout is constant
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_q;

   // only aligned NONSEQ word transfers are served; others leave hrdata unchanged, write nothing
   assign addr_valid = hsel && hready && (htrans == HTRANS_NONSEQ)
      && (hsize == HSIZE_WORD) && (haddr[1:0] == ALIGN_WORD);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end else begin
         wr_pend_q <= addr_valid && hwrite;
         if (addr_valid && hwrite) begin
            wr_addr_q <= haddr[ADDR_DEC_W-1:0];
         end
      end
   end

   // ======================================================================
   // write decode, applied in the data phase
   // refused transfers never raise wr_pend_q, so nothing below fires for them
   always_comb begin
      wr_irq_en = 1'b0;
      wr_irq_flags = 1'b0;
      wr_cap_ctrl = 1'b0;
      wr_cap_clear = 1'b0;
      wr_cap_irq_en = 1'b0;
      if (wr_pend_q) begin
         case (wr_addr_q)
            OFS_IRQ_EN: begin
               wr_irq_en = 1'b1;
            end
            OFS_IRQ_FLAGS: begin
               wr_irq_flags = 1'b1;
            end
            OFS_CAP_CTRL: begin
               wr_cap_ctrl = 1'b1;
            end
            OFS_CAP_CLEAR: begin
               wr_cap_clear = 1'b1;
            end
            OFS_CAP_IRQ_EN: begin
               wr_cap_irq_en = 1'b1;
            end
            default: begin
               wr_irq_en = 1'b0;
            end
         endcase
      end
   end

   // ======================================================================
   // read mux, sampled into hrdata at the address phase
   assign cap_ctrl_word = {
      {(DATA_W - CH1_FIELD_BASE - CH_FIELD_W){1'b0}}, chan_q[1],
      {(CH1_FIELD_BASE - CH_FIELD_W){1'b0}}, chan_q[0]
   };

   always_comb begin
      rd_val = WORD_ZERO;
      case (haddr[ADDR_DEC_W-1:0])
         OFS_IRQ_EN: begin
            rd_val[TIMERS-1:0] = timer_irq_enables_q;
         end
         OFS_IRQ_FLAGS: begin
            rd_val[TIMERS-1:0] = timer_irq_flags_q; // [R1]
         end
         OFS_CAP_CTRL: begin
            rd_val = cap_ctrl_word;
         end
         OFS_CH0_RISE: begin
            rd_val[CNT_W-1:0] = rise_latch_value[0];
         end
         OFS_CH0_FALL: begin
            rd_val[CNT_W-1:0] = fall_latch_value[0];
         end
         OFS_CH1_RISE: begin
            rd_val[CNT_W-1:0] = rise_latch_value[1];
         end
         OFS_CH1_FALL: begin
            rd_val[CNT_W-1:0] = fall_latch_value[1];
         end
         OFS_CAP_STATUS: begin
            rd_val[CAP_EVT_W-1:0] = cap_status_q;
         end
         OFS_CAP_IRQ_EN: begin
            rd_val[CAP_EVT_W-1:0] = cap_irq_en_q;
         end
         default: begin
            rd_val = WORD_ZERO;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hrdata_q <= WORD_ZERO;
      end else if (addr_valid && !hwrite) begin
         hrdata_q <= rd_val;
      end else if (addr_valid) begin
         // writes clear it so no stale read data stands in their data phase
         hrdata_q <= WORD_ZERO;
      end
   end

   // ======================================================================
   // timer interrupt enables
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         timer_irq_enables_q <= TIMER_RESET;
      end else if (wr_irq_en) begin
         timer_irq_enables_q <= hwdata[TIMERS-1:0]; // [R16]
      end
   end

   // ======================================================================
   // timer interrupt flags; a new event beats a clear in the same cycle
   always_comb begin
      timer_irq_flags_d = timer_irq_flags_q;
      if (wr_irq_flags) begin
         // ones leave a flag alone, zeros clear it
         timer_irq_flags_d = timer_irq_flags_q & hwdata[TIMERS-1:0]; // [R2]
      end
      timer_irq_flags_d = timer_irq_flags_d | timer_event; // [R1]
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         timer_irq_flags_q <= TIMER_RESET;
      end else begin
         timer_irq_flags_q <= timer_irq_flags_d; // [R1]
      end
   end

   // ======================================================================
   // capture channels and their control bytes
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      capture_channel #(
         .CNT_W(CNT_W)
      ) u_channel (
         .sys_clk(sys_clk),
         .sys_rst(sys_rst),
         .cap_pin(cap_pin[ch]),
         .input_invert(chan_q[ch].input_invert),
         .capture_enable(chan_q[ch].capture_enable),
         .count_value(counter_value[ch]),
         .captured(captured[ch]),
         .rise_latch_value_q(rise_latch_value[ch]),
         .fall_latch_value_q(fall_latch_value[ch])
      );

      // edges are already gated by capture enable inside the channel
      assign rise_irq[ch] = captured[ch].rise && chan_q[ch].rise_irq_enable; // [R7] [R10]
      assign fall_irq[ch] = captured[ch].fall && chan_q[ch].fall_irq_enable; // [R6] [R9]
      assign cap_evt[2*ch] = rise_irq[ch];
      assign cap_evt[2*ch+1] = fall_irq[ch];

      // an indication still set holds off the counter reload
      assign counter_no_reload[ch] = chan_q[ch].capture_irq_ind; // [R15]

      // this channel's byte of the written word
      chan_ctrl_type wr_byte;
      assign wr_byte = hwdata[ch*CH1_FIELD_BASE +: CH_FIELD_W];

      always_comb begin
         chan_d[ch] = chan_q[ch];
         if (wr_cap_ctrl) begin
            chan_d[ch] = wr_byte;
            // sticky bits: writing zero clears, writing one keeps
            chan_d[ch].fall_latch_dirty = chan_q[ch].fall_latch_dirty
               & wr_byte.fall_latch_dirty;
            chan_d[ch].rise_latch_dirty = chan_q[ch].rise_latch_dirty
               & wr_byte.rise_latch_dirty;
            chan_d[ch].capture_irq_ind = chan_q[ch].capture_irq_ind
               & wr_byte.capture_irq_ind;
            chan_d[ch].reserved = 1'b0;
         end
         // hardware sets come last so they win over a clear
         if (captured[ch].fall) begin
            chan_d[ch].fall_latch_dirty = 1'b1; // [R12]
         end
         if (captured[ch].rise) begin
            chan_d[ch].rise_latch_dirty = 1'b1; // [R13] [R14]
         end
         if (rise_irq[ch] || fall_irq[ch]) begin
            chan_d[ch].capture_irq_ind = 1'b1; // [R15]
         end
      end

      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            chan_q[ch] <= CHAN_CTRL_RESET;
         end else begin
            chan_q[ch] <= chan_d[ch]; // [R3] [R4] [R8] [R11]
         end
      end
   end

   // ======================================================================
   // capture interrupt status, clear and enable
   always_comb begin
      cap_status_d = cap_status_q;
      if (wr_cap_clear) begin
         cap_status_d = cap_status_q & ~hwdata[CAP_EVT_W-1:0];
      end
      cap_status_d = cap_status_d | cap_evt; // [R5]
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cap_status_q <= CAP_EVT_RESET;
      end else begin
         cap_status_q <= cap_status_d;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cap_irq_en_q <= CAP_EVT_RESET;
      end else if (wr_cap_irq_en) begin
         cap_irq_en_q <= hwdata[CAP_EVT_W-1:0];
      end
   end

   // ======================================================================
   // interrupt output, a level held until software clears the cause
   // both sources are registers, so bus activity cannot glitch the line
   assign timer_irq_pend = |(timer_irq_flags_q & timer_irq_enables_q); // [R17]
   assign cap_irq_pend = |(cap_status_q & cap_irq_en_q); // [R5]
   assign irq = timer_irq_pend || cap_irq_pend; // [R17]

endmodule : pwm_irq_flags_capture_ctrl

//--- testbench/pwm_irq_flags_capture_ctrl_checker.sv
`timescale 1ns/1ps
// ====
// port-level checks of the flags / capture block
module pwm_irq_flags_capture_ctrl_checker
   import capture_pkg::*;
#(
   parameter int CNT_W = CNT_W_DEFAULT
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // timer and pins
   input wire logic [TIMERS-1:0] timer_event,
   input wire logic [CHANNELS-1:0][CNT_W-1:0] counter_value,
   input wire logic [CHANNELS-1:0] counter_no_reload,
   input wire logic [CHANNELS-1:0] cap_pin,
   input wire logic irq
);
   logic take;
   logic wr_q;
   logic [1:0] pin_q;
   logic [3:0] age0_q;
   logic [3:0] age1_q;
   assign take = hsel & hready & (htrans == HTRANS_NONSEQ);
   // ages saturate so a quiet pin never looks recent
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q <= 1'b0;
         pin_q <= 2'h0;
         age0_q <= 4'hF;
         age1_q <= 4'hF;
      end else begin
         wr_q <= take & hwrite;
         pin_q <= cap_pin;
         age0_q <= (cap_pin[0] != pin_q[0]) ? 4'h0 : age0_q + {3'h0, age0_q != 4'hF};
         age1_q <= (cap_pin[1] != pin_q[1]) ? 4'h0 : age1_q + {3'h0, age1_q != 4'hF};
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   chk_rdata_hold: assert property (!$past(take) |-> $stable(hrdata))
      else $error("read data moved without a transfer");
   chk_ind0_cause: assert property ($rose(counter_no_reload[0]) |-> age0_q <= 4'h6)
      else $error("channel 0 indication without pin edge");
   chk_ind1_cause: assert property ($rose(counter_no_reload[1]) |-> age1_q <= 4'h6)
      else $error("channel 1 indication without pin edge");
   chk_ind0_sticky: assert property ($fell(counter_no_reload[0]) |-> $past(wr_q))
      else $error("channel 0 indication dropped without write");
   chk_ind1_sticky: assert property ($fell(counter_no_reload[1]) |-> $past(wr_q))
      else $error("channel 1 indication dropped without write");
   chk_irq_held: assert property ($fell(irq) |-> $past(wr_q))
      else $error("interrupt dropped without write");
   chk_irq_cause: assert property ($rose(irq) |->
      $past(wr_q) || $past(timer_event) != 4'h0 || age0_q < 4'h8 || age1_q < 4'h8)
      else $error("interrupt raised without cause");
endmodule : pwm_irq_flags_capture_ctrl_checker

bind pwm_irq_flags_capture_ctrl pwm_irq_flags_capture_ctrl_checker #(.CNT_W(CNT_W)) chk_i (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_event(timer_event),
   .counter_value(counter_value), .counter_no_reload(counter_no_reload),
   .cap_pin(cap_pin), .irq(irq));

//--- testbench/capture_pin_model.sv
`timescale 1ns/1ps
// ====
// external waveform source: pins follow the wanted level after a lag
module capture_pin_model (
   // clock
   input wire logic sys_clk,
   // command
   input wire logic [1:0] want,
   input wire logic [1:0] lag,
   // pins
   output logic [1:0] cap_pin
);
   logic [1:0] cnt_q;
   initial cap_pin = 2'h0;
   initial cnt_q = 2'h0;
   // levels are held many cycles, well over the two needed to be seen
   always @(posedge sys_clk) begin
      if (want == cap_pin) cnt_q <= lag;
      else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
      else cap_pin <= want;
   end
endmodule : capture_pin_model

//--- testbench/tb_pwm_irq_flags_capture_ctrl.sv
`timescale 1ns/1ps
// ====
// bench top
module tb_pwm_irq_flags_capture_ctrl
   import capture_pkg::*;
;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic irq;
   logic [31:0] hrdata;
   logic [TIMERS-1:0] timer_event = 4'h0;
   logic [CHANNELS-1:0][15:0] counter_value = '0;
   logic [CHANNELS-1:0] counter_no_reload;
   logic [CHANNELS-1:0] cap_pin;
   logic [1:0] want = 2'h0;
   logic [1:0] lag = 2'h0;
   logic [31:0] rd;
   logic [31:0] e;
   logic [31:0] en;
   logic [15:0] cv;
   logic [15:0] lat [4] = '{default: 16'h0};
   logic [7:0] ofs [6] = '{8'h40, 8'h44, 8'h50, 8'h58, 8'h70, 8'h48};
   logic inv;
   logic on;
   logic ind;
   logic [1:0] ie;
   int ch;
   int k;
   int error_cnt = 0;
   int n_tests = 0;
   always #4 sys_clk = ~sys_clk;

   pwm_irq_flags_capture_ctrl dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_event(timer_event),
      .counter_value(counter_value), .counter_no_reload(counter_no_reload),
      .cap_pin(cap_pin), .irq(irq));
   capture_pin_model pins (.sys_clk(sys_clk), .want(want), .lag(lag), .cap_pin(cap_pin));

   // ====
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   function automatic logic [31:0] exp_ctrl(input int c, input logic i, o, f,
      input logic [1:0] ie);
      return {24'h0, f & o, o, 1'b0, o & (ie[0] | (f & ie[1])), o, ie, i} << (16 * c);
   endfunction : exp_ctrl

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   initial begin
      #(8 * 5000);
      error_cnt++;
      end_of_test();
   end

   // ====
   // main sequence
   initial begin
      void'($urandom(4946));
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      foreach (ofs[i]) begin
         bus(1'b0, ofs[i], 32'h0);
         check(rd, 32'h0);
      end
      bus(1'b1, 8'h48, 32'hFFFFFFFF);
      bus(1'b0, 8'h48, 32'h0);
      check(rd, 32'h0);
      repeat (4) begin
         e = $urandom_range(15, 1);
         en = $urandom();
         k = $urandom_range(3, 0);
         bus(1'b1, 8'h40, en);
         timer_event <= e[3:0];
         @(posedge sys_clk);
         timer_event <= 4'h0;
         bus(1'b0, 8'h40, 32'h0);
         check(rd, en & 32'hF);
         bus(1'b0, 8'h44, 32'h0);
         check(rd, e);
         check({31'h0, irq}, {31'h0, |(e & en & 32'hF)});
         bus(1'b1, 8'h44, ~(32'h1 << k));
         bus(1'b0, 8'h44, 32'h0);
         check(rd, e & ~(32'h1 << k));
         bus(1'b1, 8'h44, 32'h0);
         bus(1'b0, 8'h44, 32'h0);
         check(rd, 32'h0);
         check({31'h0, irq}, 32'h0);
      end
      // modes: plain, inverted, then capture disabled
      for (int m = 0; m < 6; m++) begin
         ch = m % 2;
         inv = m[1];
         on = !m[2];
         bus(1'b1, 8'h50, 32'h0);
         bus(1'b1, 8'h78, 32'hF);
         want[ch] <= inv;
         lag <= $urandom_range(3, 0);
         // set the inverter while disabled, its toggle can fake an edge
         bus(1'b1, 8'h50, {31'h0, inv} << (16 * ch));
         repeat (8) @(posedge sys_clk);
         ie = 2'($urandom_range(3, 0));
         if (m < 2) ie = 2'b11;
         bus(1'b1, 8'h50, {28'h0, on, ie, inv} << (16 * ch));
         for (int f = 0; f < 2; f++) begin
            cv = $urandom();
            counter_value[ch] <= cv;
            want[ch] <= inv ^ !f[0];
            repeat (10) @(posedge sys_clk);
            if (on) lat[2 * ch + f] = cv;
            ind = on & (ie[0] | (f[0] & ie[1]));
            bus(1'b0, 8'h58 + 8 * ch + 4 * f, 32'h0);
            check(rd, {16'h0, lat[2 * ch + f]});
            bus(1'b0, 8'h50, 32'h0);
            check(rd, exp_ctrl(ch, inv, on, f[0], ie));
            bus(1'b0, 8'h70, 32'h0);
            check(rd, {30'h0, f[0] & on & ie[1], on & ie[0]} << (2 * ch));
            check({30'h0, counter_no_reload}, {31'h0, ind} << ch);
            check({31'h0, irq}, {31'h0, ind});
         end
         bus(1'b1, 8'h78, 32'h0);
         bus(1'b1, 8'h74, 32'hF);
         bus(1'b0, 8'h70, 32'h0);
         check(rd, 32'h0);
         check({31'h0, irq}, 32'h0);
      end
      end_of_test();
   end
endmodule : tb_pwm_irq_flags_capture_ctrl
